// ==== hw/fbx_core.sv ====
/*
  Execution core of a two-chapter four-bit microcomputer with APB access
  to program memory, decode table, control and status.
  Assumes one 40 MHz clock, synchronous K inputs, an APB master.
*/
// Implementation choices: the register addresses and register access over APB.
// Operation
// - Program memory has two chapters of 16 pages, chapter bit selects one
// - A page holds 64 eight-bit words addressed by the program counter
// - Chapter flip inverts only the chapter buffer bit
// - Taken branch or call copies chapter buffer into current chapter
// - Taken call saves current chapter into return latch, restored on return
// - Power-on reset clears program counter; execution starts at fixed address
// - Carry-affecting ops set status to carry out of the top bit
// - Inequality ops set status when compared values differ
// - Zero status lasts only one instruction cycle, then returns to one
// - Branch or call with status zero not taken; counter advances
// - Add-constant ops for constants 2 to 14 set status from carry
// - Store accumulator, increment Y, status from carry out of Y
// - Store accumulator, decrement Y, status one when no borrow
// - Memory differs from accumulator sets status, nothing modified
// - Y differs from accumulator loads status and status latch
// - File flip inverts only the top bit of X
// - Accumulator increment sets status on carry
// - Status one when accumulator is at most the memory word
// - Negate accumulator, status one when result is zero
// - Memory minus accumulator into accumulator, status when no borrow
// - Memory plus one into accumulator, memory kept, status on carry
// - Bit test sets status when the selected memory bit is one
// - Every instruction takes one cycle of six clock pulses
// - X selects one of eight files, Y one of 16 words
// - Non-affecting ops leave status one so a following jump is taken
module fbx_core (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_rst,
  input  wire logic                      i_psel,
  input  wire logic                      i_penable,
  input  wire logic                      i_pwrite,
  input  wire logic [fbx_pkg::ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]               i_pwdata,
  output logic      [31:0]               o_prdata,
  output logic                           o_pready,
  output logic                           o_pslverr,
  input  wire logic [3:0]                i_k,
  output logic      [15:0]               o_r,
  output logic      [4:0]                o_out
);
  import fbx_pkg::*;

  fbx_state_t          state_q;
  fbx_arch_t           arch_q;
  fbx_op_t             op;
  logic                run_q;
  logic [ROM_AW-1:0]   prog_addr_q;
  logic [5:0]          ret_pc_q;
  logic [3:0]          ret_page_q;
  logic [3:0]          acc_q, acc_d;
  logic [3:0]          y_q, y_d;
  logic [2:0]          x_q, x_d;
  logic                status_q, st_v;
  logic                sl_q, sl_d;
  logic [15:0]         r_d;
  logic [4:0]          out_d;
  logic [7:0]          rom_q;
  logic [5:0]          dec_q;
  logic [3:0]          mem_q;
  logic                mem_we;
  logic [3:0]          mem_wd;
  logic [4:0]          sum;
  logic                exec;
  logic [5:0]          pc_inc;
  logic [3:0]          k_c;
  logic [3:0]          bit_m;
  logic                hit;
  logic [31:0]         rd;
  logic                wr_fire;
  logic                prog_we;
  logic                dec_we;

  assign k_c    = rom_q[3:0];
  assign bit_m  = 4'h1 << rom_q[1:0];
  assign pc_inc = arch_q.pc + 6'h01;
  assign op     = fbx_op_t'(dec_q);

  // Program memory, 2 chapters x 16 pages x 64 words
  fbx_mem #(.AW(ROM_AW), .DW(8)) u_rom (
    .i_sys_clk (i_sys_clk),
    .i_we      (prog_we),
    .i_waddr   (prog_addr_q),
    .i_wdata   (i_pwdata[7:0]),
    .i_raddr   ({arch_q.chap_cur, arch_q.page, arch_q.pc}),
    .o_rdata   (rom_q)
  );

  // Opcode to operation map, loaded by software
  fbx_mem #(.AW(8), .DW(6)) u_dec (
    .i_sys_clk (i_sys_clk),
    .i_we      (dec_we),
    .i_waddr   (i_pwdata[DEC_IDX_LSB+7:DEC_IDX_LSB]),
    .i_wdata   (i_pwdata[5:0]),
    .i_raddr   (rom_q),
    .o_rdata   (dec_q)
  );

  // Data memory, file from X and word from Y
  fbx_mem #(.AW(RAM_AW), .DW(4)) u_ram (
    .i_sys_clk (i_sys_clk),
    .i_we      (mem_we && exec),
    .i_waddr   ({x_q, y_q}),
    .i_wdata   (mem_wd),
    .i_raddr   ({x_q, y_q}),
    .o_rdata   (mem_q)
  );

  fbx_phase u_phase (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_en      (state_q == st_run),
    .o_exec    (exec)
  );

  // Run control
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_q <= st_halt;
    end else begin
      case (state_q)
        st_halt: if (run_q) state_q <= st_run;
        st_run:  if (!run_q) state_q <= st_halt;
        default: state_q <= st_halt;
      endcase
    end
  end

  // Data path of one instruction
  always_comb begin
    acc_d  = acc_q;
    y_d    = y_q;
    x_d    = x_q;
    sl_d   = sl_q;
    r_d    = o_r;
    out_d  = o_out;
    mem_we = 1'b0;
    mem_wd = acc_q;
    sum    = 5'h00;
    st_v   = 1'b1;
    case (op)
      op_acc_to_y:   y_d = acc_q;
      op_y_to_acc:   acc_d = y_q;
      op_clr_acc:    acc_d = 4'h0;
      op_store_acc:  mem_we = 1'b1;
      store_acc_inc_y_op: begin
        mem_we = 1'b1;
        sum    = {1'b0, y_q} + 5'h01;
        y_d    = sum[3:0];
        st_v   = sum[4];
      end
      store_acc_dec_y_op: begin
        mem_we = 1'b1;
        sum    = {1'b0, y_q} + 5'h0F;
        y_d    = sum[3:0];
        st_v   = sum[4];
      end
      op_store_clr: begin
        mem_we = 1'b1;
        acc_d  = 4'h0;
      end
      op_mem_to_y:   y_d = mem_q;
      op_mem_to_acc: acc_d = mem_q;
      op_swap_mem: begin
        mem_we = 1'b1;
        acc_d  = mem_q;
      end
      op_add_mem: begin
        sum   = {1'b0, acc_q} + {1'b0, mem_q};
        acc_d = sum[3:0];
        st_v  = sum[4];
      end
      mem_minus_acc_op: begin
        sum   = {1'b0, mem_q} + {1'b0, ~acc_q} + 5'h01;
        acc_d = sum[3:0];
        st_v  = sum[4];
      end
      mem_plus_one_to_acc: begin
        sum   = {1'b0, mem_q} + 5'h01;
        acc_d = sum[3:0];
        st_v  = sum[4];
      end
      op_mem_dec_acc: begin
        sum   = {1'b0, mem_q} + 5'h0F;
        acc_d = sum[3:0];
        st_v  = sum[4];
      end
      acc_increment_op: begin
        sum   = {1'b0, acc_q} + 5'h01;
        acc_d = sum[3:0];
        st_v  = sum[4];
      end
      op_acc_dec: begin
        sum   = {1'b0, acc_q} + 5'h0F;
        acc_d = sum[3:0];
        st_v  = sum[4];
      end
      op_add_k: begin
        sum   = {1'b0, acc_q} + {1'b0, k_c};
        acc_d = sum[3:0];
        st_v  = sum[4];
      end
      op_y_inc: begin
        sum  = {1'b0, y_q} + 5'h01;
        y_d  = sum[3:0];
        st_v = sum[4];
      end
      op_y_dec: begin
        sum  = {1'b0, y_q} + 5'h0F;
        y_d  = sum[3:0];
        st_v = sum[4];
      end
      acc_negate_op: begin
        sum   = {1'b0, ~acc_q} + 5'h01;
        acc_d = sum[3:0];
        st_v  = (sum[3:0] == 4'h0);
      end
      acc_le_mem_compare: begin
        sum  = {1'b0, mem_q} + {1'b0, ~acc_q} + 5'h01;
        st_v = sum[4];
      end
      op_acc_le_k: begin
        sum  = {1'b0, k_c} + {1'b0, ~acc_q} + 5'h01;
        st_v = sum[4];
      end
      mem_acc_differ_test: st_v = (mem_q != acc_q);
      op_mem_nz:     st_v = (mem_q != 4'h0);
      y_acc_differ_test: begin
        st_v = (y_q != acc_q);
        sl_d = (y_q != acc_q);
      end
      op_y_ne_k:     st_v = (y_q != k_c);
      op_bit_set: begin
        mem_we = 1'b1;
        mem_wd = mem_q | bit_m;
      end
      op_bit_clr: begin
        mem_we = 1'b1;
        mem_wd = mem_q & ~bit_m;
      end
      bit_test_op:   st_v = ((mem_q & bit_m) != 4'h0);
      op_k_to_y:     y_d = k_c;
      op_k_to_mem_inc_y: begin
        mem_we = 1'b1;
        mem_wd = k_c;
        y_d    = y_q + 4'h1;
      end
      op_in_nz:      st_v = (i_k != 4'h0);
      op_in_to_acc:  acc_d = i_k;
      op_r_set:      r_d[y_q] = 1'b1;
      op_r_clr:      r_d[y_q] = 1'b0;
      op_out_load:   out_d = {sl_q, acc_q};
      op_file_load:  x_d = rom_q[2:0];
      file_msb_flip_op: x_d = {~x_q[2], x_q[1:0]};
      default: ;
    endcase
  end

  // Working registers and status, updated once per instruction cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      acc_q    <= 4'h0;
      y_q      <= 4'h0;
      x_q      <= 3'h0;
      status_q <= 1'b1;
      sl_q     <= 1'b0;
      o_r      <= 16'h0000;
      o_out    <= 5'h00;
    end else if (exec) begin
      acc_q    <= acc_d;
      y_q      <= y_d;
      x_q      <= x_d;
      status_q <= st_v;
      sl_q     <= sl_d;
      o_r      <= r_d;
      o_out    <= out_d;
    end
  end

  // Program counter, page and chapter sequencing
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      arch_q     <= ARCH_RESET;
      ret_pc_q   <= PC_RESET;
      ret_page_q <= PAGE_RESET;
    end else if (exec) begin
      arch_q.pc <= pc_inc;
      case (op)
        chapter_flip_op: arch_q.chap_buf <= ~arch_q.chap_buf;
        op_page_load:    arch_q.page_buf <= k_c;
        conditional_jump_op: begin
          if (status_q) begin
            arch_q.pc       <= rom_q[5:0];
            arch_q.page     <= arch_q.page_buf;
            arch_q.chap_cur <= arch_q.chap_buf;
          end
        end
        op_call: begin
          if (status_q) begin
            ret_pc_q        <= pc_inc;
            ret_page_q      <= arch_q.page;
            arch_q.chap_ret <= arch_q.chap_cur;
            arch_q.pc       <= rom_q[5:0];
            arch_q.page     <= arch_q.page_buf;
            arch_q.chap_cur <= arch_q.chap_buf;
          end
        end
        subroutine_return_op: begin
          arch_q.pc       <= ret_pc_q;
          arch_q.page     <= ret_page_q;
          arch_q.chap_cur <= arch_q.chap_ret;
        end
        default: ;
      endcase
    end
  end

  // APB decode
  always_comb begin
    hit = 1'b1;
    rd  = 32'h0000_0000;
    if (i_paddr == OFS_CTRL) begin
      rd[CTRL_RUN] = run_q;
    end else if (i_paddr == OFS_STAT) begin
      rd = {1'b0, state_q == st_run, status_q, sl_q, x_q, y_q, acc_q,
            ret_page_q, arch_q.chap_buf, arch_q.chap_cur, arch_q.chap_ret,
            arch_q.page, arch_q.pc};
    end else if (i_paddr == OFS_PADDR) begin
      rd = {21'h000000, prog_addr_q};
    end else if (i_paddr == OFS_PDATA || i_paddr == OFS_DECWR) begin
      rd = 32'h0000_0000;
    end else begin
      hit = 1'b0;
    end
  end

  assign wr_fire = i_psel && i_penable && o_pready && i_pwrite && hit;
  assign prog_we = wr_fire && (i_paddr == OFS_PDATA);
  assign dec_we  = wr_fire && (i_paddr == OFS_DECWR);

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= i_psel && i_penable && !o_pready;
      o_pslverr <= i_psel && i_penable && !o_pready && !hit;
      o_prdata  <= (i_psel && i_penable && !o_pready && !i_pwrite) ? rd : 32'h0000_0000;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      run_q       <= 1'b0;
      prog_addr_q <= '0;
    end else if (wr_fire) begin
      if (i_paddr == OFS_CTRL) run_q <= i_pwdata[CTRL_RUN];
      if (i_paddr == OFS_PADDR) prog_addr_q <= i_pwdata[ROM_AW-1:0];
      if (prog_we) prog_addr_q <= prog_addr_q + 11'h001;
    end
  end

  // Checks
  sequence s_flip_exec;
    exec && op == chapter_flip_op;
  endsequence

  sequence s_taken(fbx_op_t o);
    exec && op == o && status_q;
  endsequence

  chap_flip_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_flip_exec |=> arch_q.chap_buf != $past(arch_q.chap_buf)
      && $stable(arch_q.chap_cur) && $stable(arch_q.chap_ret))
    else $error("chapter flip touched more than the buffer");

  jump_taken_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_taken(conditional_jump_op) |=> arch_q.chap_cur == $past(arch_q.chap_buf)
      && arch_q.pc == $past(rom_q[5:0]))
    else $error("taken jump did not load chapter and target");

  jump_skip_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    exec && op == conditional_jump_op && !status_q |=> arch_q.pc == $past(pc_inc)
      && $stable(arch_q.chap_cur))
    else $error("jump with status zero was taken");

  call_save_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_taken(op_call) |=> arch_q.chap_ret == $past(arch_q.chap_cur)
      && ret_pc_q == $past(pc_inc))
    else $error("call did not save return chapter");

  zero_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_rst || !run_q)
    $fell(status_q) |-> (!status_q)[*6])
    else $error("zero status did not last one instruction cycle");

  status_one_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    exec && op == op_nop |=> status_q)
    else $error("status not one after non-affecting op");

  instr_cycle_a: assert property (@(posedge i_sys_clk) disable iff (i_rst || !run_q)
    exec |=> (!exec)[*5] ##1 exec)
    else $error("instruction cycle is not six clocks");

  add_k_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    exec && op == op_add_k |=>
      {status_q, acc_q} == {1'b0, $past(acc_q)} + {1'b0, $past(k_c)})
    else $error("add constant result or carry wrong");

  y_differ_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    exec && op == y_acc_differ_test |=> status_q == sl_q
      && sl_q == ($past(y_q) != $past(acc_q)))
    else $error("y differ test did not load both flags");

  reset_start_a: assert property (@(posedge i_sys_clk)
    $past(i_rst) |-> arch_q.pc == PC_RESET && arch_q.chap_cur == CHAP_RESET
      && arch_q.chap_buf == CHAP_RESET && arch_q.chap_ret == CHAP_RESET)
    else $error("reset did not clear counter and chapters");

endmodule // fbx_core

// ==== hw/fbx_mem.sv ====
/*
  Simple dual-port memory with one write port and a registered read port.
  Assumes the caller keeps the read address stable for a cycle to see data.
*/
module fbx_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic          i_sys_clk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);

  logic [DW-1:0] mem_q [2**AW];

  always_ff @(posedge i_sys_clk) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    o_rdata <= mem_q[i_raddr];
  end

endmodule // fbx_mem

// ==== hw/fbx_phase.sv ====
/*
  Instruction cycle divider: one execute pulse every PH_CYCLES clocks.
  Assumes synchronous active-high reset; count restarts while disabled.
*/
module fbx_phase (
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  input  wire logic i_en,
  output logic      o_exec
);
  import fbx_pkg::*;

  logic [2:0] cnt_q;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !i_en) begin
      cnt_q  <= 3'h0;
      o_exec <= 1'b0;
    end else begin
      o_exec <= (cnt_q == 3'(PH_CYCLES - 2));
      cnt_q  <= (cnt_q == 3'(PH_CYCLES - 1)) ? 3'h0 : cnt_q + 3'h1;
    end
  end

endmodule // fbx_phase

// ==== hw/fbx_pkg.sv ====
/*
  Package of the four-bit execution core: register map, reset values,
  instruction cycle length, operation codes and the architectural state.
  Assumes a single 40 MHz clock and an APB master with 32-bit data.
*/
package fbx_pkg;

  localparam int          ADDR_W      = 12;
  localparam int          ROM_AW      = 11;
  localparam int          RAM_AW      = 7;
  localparam int          PH_CYCLES   = 6;

  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_STAT    = 12'h004;
  localparam logic [11:0] OFS_PADDR   = 12'h008;
  localparam logic [11:0] OFS_PDATA   = 12'h00C;
  localparam logic [11:0] OFS_DECWR   = 12'h010;

  localparam int          CTRL_RUN    = 0;
  localparam int          DEC_IDX_LSB = 8;
  localparam logic [5:0]  PC_RESET    = 6'h00;
  localparam logic [3:0]  PAGE_RESET  = 4'hF;
  localparam logic        CHAP_RESET  = 1'h0;

  typedef enum logic [1:0] {
    st_halt = 2'b01,
    st_run  = 2'b10
  } fbx_state_t;

  typedef enum logic [5:0] {
    op_nop, op_acc_to_y, op_y_to_acc, op_clr_acc, op_store_acc,
    store_acc_inc_y_op, store_acc_dec_y_op, op_store_clr, op_mem_to_y,
    op_mem_to_acc, op_swap_mem, op_add_mem, mem_minus_acc_op,
    mem_plus_one_to_acc, op_mem_dec_acc, acc_increment_op, op_acc_dec,
    op_add_k, op_y_inc, op_y_dec, acc_negate_op, acc_le_mem_compare,
    op_acc_le_k, mem_acc_differ_test, op_mem_nz, y_acc_differ_test,
    op_y_ne_k, op_bit_set, op_bit_clr, bit_test_op, op_k_to_y,
    op_k_to_mem_inc_y, op_in_nz, op_in_to_acc, op_r_set, op_r_clr,
    op_out_load, op_file_load, file_msb_flip_op, conditional_jump_op,
    op_call, subroutine_return_op, op_page_load, chapter_flip_op
  } fbx_op_t;

  typedef struct packed {
    logic       chap_buf;
    logic       chap_cur;
    logic       chap_ret;
    logic [3:0] page_buf;
    logic [3:0] page;
    logic [5:0] pc;
  } fbx_arch_t;

  localparam fbx_arch_t ARCH_RESET = '{CHAP_RESET, CHAP_RESET, CHAP_RESET,
                                       PAGE_RESET, PAGE_RESET, PC_RESET};

endpackage

// ==== verif/four_bit_mcu_exec_core_tb.sv ====
/*
  Self-checking bench of the execution core: loads program memory and the
  decode table over APB, runs short programs and compares the status word
  and output latches with a behavioural model kept in the bench.
  Assumes the design package and core of hw/ and one 40 MHz clock.
*/
module four_bit_mcu_exec_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fbx_pkg::*;

  logic        clk, rst, psel, pen, pwr, err, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  k;
  logic [15:0] r_o, mr;
  logic [4:0]  out_o;
  bit   [31:0] rnd;
  int          fail_count, checked, cyc, called, mk, moo;
  int          ma, mx, my, mst, msl, mpc, mpg, mpb, mcc, mcb, mcr, mrpc, mrpg;
  int          ram[128], rom[2048], cl[$];
  logic [7:0]  pq[$];
  fbx_op_t     tab[256];
  fbx_op_t     ext[16] = '{op_acc_dec, op_y_inc, op_y_dec, acc_negate_op,
    acc_le_mem_compare, mem_acc_differ_test, op_mem_nz, y_acc_differ_test,
    op_in_nz, op_in_to_acc, op_r_set, op_r_clr, op_out_load,
    file_msb_flip_op, subroutine_return_op, chapter_flip_op};
  int          ops[29] = '{8'h05, 8'h06, 8'h55, 8'h57, 8'h0F, 8'h54, 8'h53,
    8'h0C, 8'h0D, 8'h70, 8'h5D, 8'h59, 8'h58, 8'h0B, 8'h74, 8'h01, 8'h03,
    8'h04, 8'h07, 8'h08, 8'h0A, 8'h0E, 8'h50, 8'h51, 8'h52, 8'h56, 8'h5B,
    8'h78, 8'h7C};

  fbx_core dut (.i_sys_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_k(k), .o_r(r_o), .o_out(out_o));

  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      stop_test();
    end
  end

  function automatic int rn(int m);
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd % m;
  endfunction

  // Bench decode table: high nibble picks the group, low bits the operand
  function automatic fbx_op_t opof(int w);
    if (w >= 192) return conditional_jump_op;
    if (w >= 128) return op_call;
    case (w / 16)
      0: return fbx_op_t'(w);
      1: return op_add_k;
      2: return op_k_to_y;
      3: return op_file_load;
      4: return op_page_load;
      5: return ext[w % 16];
      6: return op_k_to_mem_inc_y;
      7: return (w % 16 < 4) ? bit_test_op : (w % 16 < 8) ? op_bit_set :
                (w % 16 < 12) ? op_bit_clr : (w % 16 < 14) ? op_acc_le_k : op_y_ne_k;
      default: return op_nop;
    endcase
  endfunction

  task automatic chk(logic [31:0] got, logic [31:0] exp, string s);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic apb(bit w, logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    psel   <= 1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q   = prdata;
    err = pslverr;
    psel <= 0;
    pen  <= 0;
  endtask

  task automatic wr(int a, int d);
    apb(1, 12'(a), 32'(d));
  endtask

  task automatic p(int w);
    pq.push_back(8'(w));
  endtask

  task automatic load(int a);
    wr(OFS_PADDR, a);
    foreach (pq[i]) begin
      wr(OFS_PDATA, pq[i]);
      rom[a + i] = pq[i];
      cl.push_back(a + i);
    end
    pq.delete();
  endtask

  task automatic mreset(int c);
    rst <= 1;
    repeat (c) @(posedge clk);
    rst <= 0;
    {ma, mx, my, msl, mpc, mcc, mcb, mcr, mrpc, mrpg, called, moo} = 0;
    mr  = 0;
    mst = 1;
    mpg = 15;
    mpb = 15;
  endtask

  task automatic step();
    int i, m, w, v, n, npc;
    i = mx * 16 + my;
    m = ram[i];
    w = rom[mcc * 1024 + mpg * 64 + mpc];
    v = w % 16;
    n = mst;
    mst = 1;
    npc = (mpc + 1) % 64;
    case (tab[w])
      op_acc_to_y: my = ma;
      op_y_to_acc: ma = my;
      op_clr_acc: ma = 0;
      op_store_acc: ram[i] = ma;
      store_acc_inc_y_op: begin ram[i] = ma; mst = (my == 15); my = (my + 1) % 16; end
      store_acc_dec_y_op: begin ram[i] = ma; mst = (my != 0); my = (my + 15) % 16; end
      op_store_clr: begin ram[i] = ma; ma = 0; end
      op_mem_to_y: my = m;
      op_mem_to_acc: ma = m;
      op_swap_mem: begin ram[i] = ma; ma = m; end
      op_add_mem: begin mst = (m + ma > 15); ma = (m + ma) % 16; end
      mem_minus_acc_op: begin mst = (m >= ma); ma = (m - ma + 16) % 16; end
      mem_plus_one_to_acc: begin mst = (m == 15); ma = (m + 1) % 16; end
      op_mem_dec_acc: begin mst = (m != 0); ma = (m + 15) % 16; end
      acc_increment_op: begin mst = (ma == 15); ma = (ma + 1) % 16; end
      op_acc_dec: begin mst = (ma != 0); ma = (ma + 15) % 16; end
      op_add_k: begin mst = (ma + v > 15); ma = (ma + v) % 16; end
      op_y_inc: begin mst = (my == 15); my = (my + 1) % 16; end
      op_y_dec: begin mst = (my != 0); my = (my + 15) % 16; end
      acc_negate_op: begin ma = (16 - ma) % 16; mst = (ma == 0); end
      acc_le_mem_compare: mst = (ma <= m);
      op_acc_le_k: mst = (ma <= v);
      op_y_ne_k: mst = (my != v);
      mem_acc_differ_test: mst = (m != ma);
      op_mem_nz: mst = (m != 0);
      y_acc_differ_test: begin mst = (my != ma); msl = mst; end
      bit_test_op: mst = (m >> (w % 4)) & 1;
      op_bit_set: ram[i] = m | (1 << (w % 4));
      op_bit_clr: ram[i] = m & ~(1 << (w % 4));
      op_k_to_y: my = v;
      op_k_to_mem_inc_y: begin ram[i] = v; my = (my + 1) % 16; end
      op_in_nz: mst = (mk != 0);
      op_in_to_acc: ma = mk;
      op_r_set: mr[my] = 1'b1;
      op_r_clr: mr[my] = 1'b0;
      op_out_load: moo = msl * 16 + ma;
      op_file_load: mx = w % 8;
      file_msb_flip_op: mx = mx ^ 4;
      conditional_jump_op: if (n) begin npc = w % 64; mpg = mpb; mcc = mcb; end
      op_call: if (n) begin
        {mrpc, mrpg, mcr, called} = {npc, mpg, mcc, 1};
        {npc, mpg, mcc} = {w % 64, mpb, mcb};
      end
      subroutine_return_op: {npc, mpg, mcc} = {mrpc, mrpg, mcr};
      op_page_load: mpb = v;
      chapter_flip_op: mcb = mcb ^ 1;
      default: ;
    endcase
    mpc = npc;
  endtask

  function automatic logic [31:0] estat();
    return {2'b0, mst[0], msl[0], 3'(mx), 4'(my), 4'(ma), 4'(mrpg),
            mcb[0], mcc[0], mcr[0], 4'(mpg), 6'(mpc)};
  endfunction

  // Return page is masked out of the status compare until a call has been taken
  task automatic cmpstat(string s);
    logic [31:0] m;
    m = called ? 32'hFFFFFFFF : 32'hFFFE1FFF;
    apb(0, OFS_STAT, 0);
    chk(q & m, estat() & m, s);
    chk(r_o, mr, s);
    chk(out_o, moo, s);
  endtask

  task automatic run(string s);
    int n;
    n = 0;
    mk = rn(16);
    k <= 4'(mk);
    while (!(rom[mcc * 1024 + mpg * 64 + mpc] == 255 && mpc == 63 &&
             mpb == mpg && mcb == mcc) && n < 200) begin
      step();
      n++;
    end
    wr(OFS_CTRL, 1);
    repeat ((n + 3) * PH_CYCLES) @(posedge clk);
    wr(OFS_CTRL, 0);
    repeat (2 * PH_CYCLES) @(posedge clk);
    cmpstat(s);
    foreach (cl[i]) begin
      wr(OFS_PADDR, cl[i]);
      wr(OFS_PDATA, 255);
      rom[cl[i]] = 255;
    end
    cl.delete();
    $display("test %s done", s);
  endtask

  initial begin
    int a, rx, ry, ra, rm, w;
    rnd = 32'h77EA9B6F;
    {psel, pen, pwr} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    k = 4'h0;
    rst = 1;
    mreset(12);
    cmpstat("reset");
    apb(0, 12'h020, 0);
    chk(q, 0, "unmapped read data");
    chk(err, 1, "unmapped error");
    // Every empty word is a conditional jump to word 63 of the buffered page, a self loop
    wr(OFS_PADDR, 0);
    repeat (2048) wr(OFS_PDATA, 255);
    foreach (rom[i]) rom[i] = 255;
    for (int i = 0; i < 256; i++) begin
      tab[i] = opof(i);
      wr(OFS_DECWR, {16'h0, 8'(i), 2'b0, 6'(tab[i])});
    end
    for (int c = 2; c <= 14; c++) begin
      mreset(2);
      a = (c == 2) ? 14 : rn(16);
      p(32 + a); p(2); p(32 + c); p(16 + c);
      p(192 + pq.size() + 2); p(8'h5A); p(8'h5C); p(255); p(255);
      load(960);
      run("add constant");
    end
    for (int it = 0; it < 5; it++) begin
      foreach (ops[o]) begin
        mreset(2);
        {rx, ry, ra, rm} = {rn(8), rn(16), rn(16), rn(16)};
        if (it == 0) {ra, rm} = {ry, ry};
        if (it == 1) {ra, rm, ry} = {15, 15, 0};
        if (it == 2) {ra, rm, ry} = {0, 0, 15};
        w = ops[o];
        if (w / 16 == 7) w += rn(4);
        p(48 + (rx ^ 4)); p(32 + ry); p(96 + rn(16)); p(48 + rx); p(32 + ry);
        p(96 + rm); p(32 + ra); p(2); p(32 + ry); p(w);
        p(192 + pq.size() + 2); p(8'h5A); p(8'h5C); p(32 + ry); p(9);
        p(255); p(255);
        load(960);
        run("arithmetic");
      end
    end
    mreset(2);
    p(37); p(2); p(37); p(8'h57); p(128); p(8'h57); p(0);
    p(192 + pq.size() + 2); p(8'h5A); p(8'h5F); p(128); p(41); p(8'h5A);
    p(79); p(8'h5C); p(255); p(255);
    load(960);
    p(35); p(8'h5A); p(8'h5F); p(8'h5F); p(8'h5E);
    load(1984);
    run("chapter");
    stop_test();
  end
endmodule // four_bit_mcu_exec_core_tb
